// *** mss_sequencer.sv ***
// Motor start/stop sequencer: start logic, direct-online and slow-speed
`timescale 1ns/1ps
`default_nettype none
`include "mss_regs.svh"
// Operation
// - Slow speed Off refuses slow operation
// - Slow operation regulates to slow current level
// - Limit slow run time; Off disables
// - Limit timer also counts kick phase
// - Timer clears whenever motor stopped
// - Kick level Off skips kick phase
// - Kick level for kick time, then slow
// - Direct-online start energizes run relays
// - At speed energizes at-speed relays
// - Direct-online suppresses thyristor and stack faults
// - Direct-online ignores ramp, kick, deceleration
// - Direct-online holds gate drive inactive
// - Two-wire runs only while start held
// - Three-wire runs until stop input low
// - Start edge picks three-wire if stop high
// - Three-wire latches start internally
// - Slow request only idle, terminal source
// - Slow forward/reverse from assigned inputs
// - Slow relays energized during slow operation
module mss_sequencer #(
    parameter int TICK_CYCLES = `MSS_TICK_CYCLES
) (
    input  wire logic                            ref_clk,
    input  wire logic                            reset,
    input  wire logic                            startIn,
    input  wire logic [`MSS_NUM_DI-1:0]          digitalIn,
    input  wire logic [3*`MSS_NUM_DI-1:0]        diFunc,
    input  wire logic [2*`MSS_NUM_RELAY-1:0]     relayFunc,
    input  wire logic                            sourceTerminal,
    input  wire logic                            directOnlineMode,
    input  wire logic                            motorAtSpeed,
    input  wire logic                            faultTrip,
    input  wire logic [`MSS_SPEED_W-1:0]         slowSpeedSel,
    input  wire logic [`MSS_LEVEL_W-1:0]         slowCurrentLevel,
    input  wire logic [`MSS_LEVEL_W-1:0]         slowKickLevel,
    input  wire logic [`MSS_TIME_W-1:0]          slowKickTime,
    input  wire logic [`MSS_TIME_W-1:0]          slowTimeLimit,
    input  wire logic [`MSS_LEVEL_W-1:0]         rampCurrentLevel,
    input  wire logic                            failedThyristorIn,
    input  wire logic                            stackOverloadIn,
    output logic [`MSS_NUM_RELAY-1:0]            relayOut,
    output logic                                 gateEnable,
    output logic [`MSS_LEVEL_W-1:0]              currentSetpoint,
    output logic [`MSS_SPEED_W-1:0]              speedSetpoint,
    output logic                                 slowReverse,
    output logic                                 threeWire,
    output logic                                 failedThyristorTrip,
    output logic                                 stackOverloadTrip,
    output logic                                 slowLimitReached
);
    mss_pkg::mss_state_type state;        // Current sequencer state
    mss_pkg::mss_state_type next_state;   // Next sequencer state
    logic                   startPrev;    // Start input one cycle ago
    logic                   runLatch;     // Internal seal-in for three-wire
    logic [`MSS_TIME_W-1:0] slowTimer;    // Continuous slow time in ticks
    logic [`MSS_TIME_W-1:0] kickTimer;    // Kick phase time in ticks
    logic                   tick;         // Timer tick enable
    logic                   atSpeedFlag;  // Motor reported at speed
    logic                   slowLock;     // Limit reached, request still held

    // Timer tick from the divider
    mss_tick_div #(.TICK_CYCLES(TICK_CYCLES)) uTick (
        .ref_clk (ref_clk),
        .reset   (reset),
        .tick    (tick)
    );

    // Decode the assigned functions of each digital input
    logic [`MSS_NUM_DI-1:0] stopAssigned;
    logic [`MSS_NUM_DI-1:0] slowFwdHigh;
    logic [`MSS_NUM_DI-1:0] slowRevHigh;
    genvar gi;
    generate
        for (gi = 0; gi < `MSS_NUM_DI; gi++) begin : gDi
            assign stopAssigned[gi] = (diFunc[3*gi +: 3] == `MSS_DI_STOP);
            assign slowFwdHigh[gi]  = (diFunc[3*gi +: 3] == `MSS_DI_SLOW_FWD) & digitalIn[gi];
            assign slowRevHigh[gi]  = (diFunc[3*gi +: 3] == `MSS_DI_SLOW_REV) & digitalIn[gi];
        end
    endgenerate

    // Stop is present when any assigned stop input is high
    wire stopHigh  = |(stopAssigned & digitalIn);
    // Stop condition: any assigned stop input low
    wire stopLow   = |(stopAssigned & ~digitalIn);
    wire startEdge = startIn & ~startPrev;
    // Three-wire chosen at each start edge, held otherwise
    wire next_threeWire = startEdge ? stopHigh : threeWire;

    // Run command from two-wire or three-wire logic
    wire next_runLatch = startEdge ? stopHigh
                        : (runLatch & ~stopLow);
    wire runCmd = next_threeWire ? next_runLatch
                                 : startIn;

    // Slow-speed request from assigned inputs
    wire slowFwdReq = |slowFwdHigh;
    wire slowRevReq = |slowRevHigh;
    wire slowReq    = slowFwdReq ^ slowRevReq;
    wire slowAllowed = (slowSpeedSel != `MSS_OFF_SPEED)
                     & sourceTerminal & ~directOnlineMode;
    wire kickEnabled = (slowKickLevel != `MSS_OFF_LEVEL);
    wire limitOn     = (slowTimeLimit != `MSS_OFF_TIME);
    wire limitHit    = limitOn & (slowTimer >= slowTimeLimit);
    wire kickDone    = (kickTimer >= slowKickTime);

    // Next-state decision
    always_comb begin
        next_state = state;
        case (state)
            mss_pkg::MSS_IDLE: begin
                if (faultTrip) begin
                    next_state = mss_pkg::MSS_IDLE;
                end else if (runCmd & startEdge) begin
                    next_state = directOnlineMode ? mss_pkg::MSS_RUN_DOL
                                                  : mss_pkg::MSS_RUN_SOFT;
                end else if (slowReq & slowAllowed & ~slowLock) begin
                    next_state = kickEnabled ? mss_pkg::MSS_SLOW_KICK
                                             : mss_pkg::MSS_SLOW_RUN;
                end
            end
            mss_pkg::MSS_RUN_SOFT, mss_pkg::MSS_RUN_DOL: begin
                if (faultTrip | ~runCmd) begin
                    next_state = mss_pkg::MSS_IDLE;
                end
            end
            mss_pkg::MSS_SLOW_KICK: begin
                if (faultTrip | ~slowReq | limitHit) begin
                    next_state = mss_pkg::MSS_IDLE;
                end else if (kickDone) begin
                    next_state = mss_pkg::MSS_SLOW_RUN;
                end
            end
            mss_pkg::MSS_SLOW_RUN: begin
                if (faultTrip | ~slowReq | limitHit) begin
                    next_state = mss_pkg::MSS_IDLE;
                end
            end
            default: begin
                next_state = mss_pkg::MSS_IDLE;
            end
        endcase
    end

    wire inSlow  = (state == mss_pkg::MSS_SLOW_KICK) | (state == mss_pkg::MSS_SLOW_RUN);
    wire inKick  = (state == mss_pkg::MSS_SLOW_KICK);
    wire inDol   = (state == mss_pkg::MSS_RUN_DOL);
    wire inSoft  = (state == mss_pkg::MSS_RUN_SOFT);
    wire running = inDol | inSoft;

    // Current setpoint: direct-online ignores ramp and kick settings
    wire [`MSS_LEVEL_W-1:0] next_current =
        inKick ? slowKickLevel
      : (state == mss_pkg::MSS_SLOW_RUN) ? slowCurrentLevel
      : inSoft ? rampCurrentLevel
      : `MSS_OFF_LEVEL;
    wire [`MSS_SPEED_W-1:0] next_speed = inSlow ? slowSpeedSel : `MSS_OFF_SPEED;

    // Timers: slow timer runs through kick and slow run, clears when stopped
    wire [`MSS_TIME_W-1:0] next_slowTimer =
        ~inSlow ? `MSS_OFF_TIME
      : (tick & limitOn & ~limitHit) ? slowTimer + 1'b1
      : slowTimer;
    wire [`MSS_TIME_W-1:0] next_kickTimer =
        ~inKick ? `MSS_OFF_TIME
      : (tick & ~kickDone) ? kickTimer + 1'b1
      : kickTimer;

    // State and start-logic registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state     <= mss_pkg::MSS_IDLE;
            startPrev <= 1'b0;
            runLatch  <= 1'b0;
            threeWire <= 1'b0;
        end else begin
            state     <= next_state;
            startPrev <= startIn;
            runLatch  <= next_runLatch;
            threeWire <= next_threeWire;
        end
    end

    // Timer registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            slowTimer <= `MSS_OFF_TIME;
            kickTimer <= `MSS_OFF_TIME;
        end else begin
            slowTimer <= next_slowTimer;
            kickTimer <= next_kickTimer;
        end
    end

    // Lockout after the limit: a held request may not restart
    // slow speed, which would clear the timer and run on
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            slowLock <= 1'b0;
        end else begin
            slowLock <= (inSlow & limitHit) | (slowLock & slowReq);
        end
    end

    // Control outputs
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gateEnable          <= 1'b0;
            currentSetpoint     <= `MSS_OFF_LEVEL;
            speedSetpoint       <= `MSS_OFF_SPEED;
            slowReverse         <= 1'b0;
            atSpeedFlag         <= 1'b0;
            failedThyristorTrip <= 1'b0;
            stackOverloadTrip   <= 1'b0;
            slowLimitReached    <= 1'b0;
        end else begin
            gateEnable          <= (inSoft | inSlow) & ~directOnlineMode;
            currentSetpoint     <= next_current;
            speedSetpoint       <= next_speed;
            slowReverse         <= inSlow & slowRevReq;
            atSpeedFlag         <= running & motorAtSpeed;
            failedThyristorTrip <= failedThyristorIn & ~directOnlineMode;
            stackOverloadTrip   <= stackOverloadIn & ~directOnlineMode;
            slowLimitReached    <= inSlow & limitHit;
        end
    end

    // One function decoder per relay
    genvar gr;
    generate
        for (gr = 0; gr < `MSS_NUM_RELAY; gr++) begin : gRelay
            mss_relay_map uRelay (
                .ref_clk    (ref_clk),
                .reset      (reset),
                .relayFunc  (relayFunc[2*gr +: 2]),
                .runActive  (running),
                .atSpeed    (atSpeedFlag),
                .slowActive (inSlow),
                .relayOut   (relayOut[gr])
            );
        end
    endgenerate

    // Assertions
    property p_gate_off_dol;
        @(posedge ref_clk) disable iff (reset)
        directOnlineMode |=> !gateEnable;
    endproperty
    a_gate_off_dol: assert property (p_gate_off_dol) else $error("gate on in direct-online");

    property p_slow_off;
        @(posedge ref_clk) disable iff (reset)
        (state == mss_pkg::MSS_IDLE && slowSpeedSel == `MSS_OFF_SPEED) |=> !inSlow;
    endproperty
    a_slow_off: assert property (p_slow_off) else $error("slow entered while Off");

    property p_timer_clear;
        @(posedge ref_clk) disable iff (reset)
        !inSlow |=> (slowTimer == `MSS_OFF_TIME);
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("slow timer not cleared");

    property p_no_kick;
        @(posedge ref_clk) disable iff (reset)
        (state == mss_pkg::MSS_IDLE && !kickEnabled) |=> (state != mss_pkg::MSS_SLOW_KICK);
    endproperty
    a_no_kick: assert property (p_no_kick) else $error("kick entered while Off");

    sequence s_limit_hit;
        inSlow && limitHit && !faultTrip;
    endsequence
    property p_limit_idle;
        @(posedge ref_clk) disable iff (reset)
        s_limit_hit |=> (state == mss_pkg::MSS_IDLE) ##1 slowLimitReached == 1'b0;
    endproperty
    a_limit_idle: assert property (p_limit_idle) else $error("limit did not end slow");

    property p_slow_relay;
        @(posedge ref_clk) disable iff (reset)
        (inSlow && relayFunc[5:4] == `MSS_RLY_SLOW) |=> relayOut[2];
    endproperty
    a_slow_relay: assert property (p_slow_relay) else $error("slow relay not on");

    property p_run_relay;
        @(posedge ref_clk) disable iff (reset)
        (running && relayFunc[1:0] == `MSS_RLY_RUN) |=> relayOut[0];
    endproperty
    a_run_relay: assert property (p_run_relay) else $error("run relay not on");

    property p_two_wire_stop;
        @(posedge ref_clk) disable iff (reset)
        (running && !threeWire && !startIn && !startEdge) |=> (state == mss_pkg::MSS_IDLE);
    endproperty
    a_two_wire_stop: assert property (p_two_wire_stop) else $error("two-wire did not stop");

    property p_trip_mask;
        @(posedge ref_clk) disable iff (reset)
        directOnlineMode |=> !failedThyristorTrip && !stackOverloadTrip;
    endproperty
    a_trip_mask: assert property (p_trip_mask) else $error("masked trip in direct-online");

    property p_slow_lock;
        @(posedge ref_clk) disable iff (reset)
        slowLock |=> !inSlow;
    endproperty
    a_slow_lock: assert property (p_slow_lock) else $error("slow restarted after limit");

    property p_fault_idle;
        @(posedge ref_clk) disable iff (reset)
        faultTrip |=> (state == mss_pkg::MSS_IDLE);
    endproperty
    a_fault_idle: assert property (p_fault_idle) else $error("fault did not stop");

    property p_dol_setpoint;
        @(posedge ref_clk) disable iff (reset)
        inDol |=> (currentSetpoint == `MSS_OFF_LEVEL);
    endproperty
    a_dol_setpoint: assert property (p_dol_setpoint) else $error("setpoint in direct-online");

    property p_three_wire_hold;
        @(posedge ref_clk) disable iff (reset)
        (running && threeWire && !startEdge && !stopLow && !faultTrip) |=> running;
    endproperty
    a_three_wire_hold: assert property (p_three_wire_hold) else $error("run not held");

    sequence s_at_speed_req;
        running && motorAtSpeed && relayFunc[3:2] == `MSS_RLY_AT_SPEED;
    endsequence
    property p_at_speed_relay;
        @(posedge ref_clk) disable iff (reset)
        s_at_speed_req |=> ##1 relayOut[1];
    endproperty
    a_at_speed_relay: assert property (p_at_speed_relay) else $error("at-speed relay off");
endmodule
`default_nettype wire

// *** mss_regs.svh ***
// Constants for the motor start/stop sequencer
`ifndef MSS_REGS_SVH
`define MSS_REGS_SVH

// Tick divider: 125 MHz clock to a 100 ms tick
`define MSS_TICK_PERIOD_NS   100000000
`define MSS_CLK_PERIOD_NS    8
`define MSS_TICK_CYCLES      (`MSS_TICK_PERIOD_NS / `MSS_CLK_PERIOD_NS)
`define MSS_TICK_CNT_W       24

// Setting widths and the Off encoding shared by all settings
`define MSS_SPEED_W          4
`define MSS_LEVEL_W          8
`define MSS_TIME_W           16
`define MSS_OFF_SPEED        4'h0
`define MSS_OFF_LEVEL        8'h00
`define MSS_OFF_TIME         16'h0000

// Number of terminal digital inputs and relay outputs
`define MSS_NUM_DI           4
`define MSS_NUM_RELAY        4

// Digital input function codes
`define MSS_DI_NONE          3'h0
`define MSS_DI_STOP          3'h1
`define MSS_DI_SLOW_FWD      3'h2
`define MSS_DI_SLOW_REV      3'h3

// Relay output function codes
`define MSS_RLY_NONE         2'h0
`define MSS_RLY_RUN          2'h1
`define MSS_RLY_AT_SPEED     2'h2
`define MSS_RLY_SLOW         2'h3

`endif

// *** mss_pkg.sv ***
// Types for the motor start/stop sequencer
package mss_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        MSS_IDLE,
        MSS_RUN_SOFT,
        MSS_RUN_DOL,
        MSS_SLOW_KICK,
        MSS_SLOW_RUN
    } mss_state_type;
endpackage

// *** mss_tick_div.sv ***
// Divider that makes a one-cycle timer tick enable
`timescale 1ns/1ps
`default_nettype none
`include "mss_regs.svh"
module mss_tick_div #(
    parameter int TICK_CYCLES = `MSS_TICK_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    output logic      tick
);
    logic [`MSS_TICK_CNT_W-1:0] count;   // Cycles since last tick
    wire                        atEnd = (count == `MSS_TICK_CNT_W'(TICK_CYCLES - 1));

    // Count cycles and pulse tick once per period
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= atEnd ? '0 : count + 1'b1;
            tick  <= atEnd;
        end
    end
endmodule
`default_nettype wire

// *** mss_relay_map.sv ***
// Drives each relay from the function assigned to it
`timescale 1ns/1ps
`default_nettype none
`include "mss_regs.svh"
module mss_relay_map (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [1:0] relayFunc,
    input  wire logic       runActive,
    input  wire logic       atSpeed,
    input  wire logic       slowActive,
    output logic            relayOut
);
    // Select the condition that this relay follows
    wire nextRelay = (relayFunc == `MSS_RLY_RUN)      ? runActive  :
                     (relayFunc == `MSS_RLY_AT_SPEED) ? atSpeed    :
                     (relayFunc == `MSS_RLY_SLOW)     ? slowActive : 1'b0;

    // Register the relay drive
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            relayOut <= 1'b0;
        end else begin
            relayOut <= nextRelay;
        end
    end
endmodule
`default_nettype wire

// *** mss_far_side.sv ***
// Far-side model: start button, stop circuit, selector switch and slow-speed switches
`timescale 1ns/1ps
`default_nettype none
module mss_far_side (
    input  wire logic        ref_clk,
    output logic             startIn,
    output logic [3:0]       digitalIn,
    output logic [15:0]      slowKickTime
);
    // Everything open at power-up
    initial begin
        startIn = 1'b0;
        digitalIn = 4'h0;
        slowKickTime = 16'h0000;
    end

    // Selector in Hand powers the stop circuit on input 0; Auto or a pressed stop opens it
    task automatic hand(input logic on);
        @(posedge ref_clk) digitalIn[0] <= on;
    endtask

    // Start pushbutton or plant run contact
    task automatic start(input logic on);
        @(posedge ref_clk) startIn <= on;
    endtask

    // Slow forward on input 1, slow reverse on input 2
    task automatic slow(input logic fwd, input logic rev);
        @(posedge ref_clk) digitalIn[2:1] <= {rev, fwd};
    endtask

    // Operator tunes kick time upward from ten ticks, one tick a step
    task automatic tuneKick(input int steps);
        @(posedge ref_clk) slowKickTime <= 16'h000A + 16'(steps);
    endtask
endmodule
`default_nettype wire

// *** mss_sequencer_tb_top.sv ***
// Self-checking bench for the motor start/stop sequencer
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_tb_top;
    logic        ref_clk;           // 125 MHz clock
    logic        reset;             // Asynchronous, active high
    logic        startIn;           // From the far-side model
    logic [3:0]  digitalIn;         // From the far-side model
    logic [15:0] slowKickTime;      // Tuned by the far-side model
    logic        sourceTerminal;    // Terminal control source
    logic        directOnlineMode;  // Full-voltage starter mode
    logic        motorAtSpeed;      // Speed detection input
    logic        failedThyristorIn; // Fault source
    logic        stackOverloadIn;   // Fault source
    logic [3:0]  slowSpeedSel;      // Slow speed, zero is Off
    logic [7:0]  slowCurrentLevel;  // Slow current level
    logic [7:0]  slowKickLevel;     // Kick level, zero is Off
    logic [15:0] slowTimeLimit;     // Limit in ticks, zero is Off
    logic [7:0]  rampCurrentLevel;  // Ramp level, ignored in direct-online
    logic [3:0]  relayOut;          // Relay outputs
    logic        gateEnable;        // Gate drive enable
    logic [7:0]  currentSetpoint;   // Current regulation target
    logic [3:0]  speedSetpoint;     // Slow speed target
    logic        slowReverse;       // Slow direction
    logic        threeWire;         // Selected start/stop logic
    logic        failedThyristorTrip;
    logic        stackOverloadTrip;
    logic        slowLimitReached;
    logic [11:0] diFunc;            // Input functions
    logic [7:0]  relayFunc;         // Relay functions
    logic        faultTrip;         // Protection trip
    int          limitPulses = 0;   // Limit pulses seen
    int          checked;           // Comparisons made
    int          miscompares;       // Mismatches found

    // Inputs 0..2: stop, slow fwd, slow rev; relays 0..2: run, at-speed, slow
    mss_sequencer #(.TICK_CYCLES(10)) u_mss_sequencer (
        .ref_clk(ref_clk), .reset(reset), .startIn(startIn), .digitalIn(digitalIn),
        .diFunc(diFunc), .relayFunc(relayFunc), .sourceTerminal(sourceTerminal),
        .directOnlineMode(directOnlineMode), .motorAtSpeed(motorAtSpeed),
        .faultTrip(faultTrip), .slowSpeedSel(slowSpeedSel), .slowCurrentLevel(slowCurrentLevel),
        .slowKickLevel(slowKickLevel), .slowKickTime(slowKickTime),
        .slowTimeLimit(slowTimeLimit), .rampCurrentLevel(rampCurrentLevel),
        .failedThyristorIn(failedThyristorIn), .stackOverloadIn(stackOverloadIn),
        .relayOut(relayOut), .gateEnable(gateEnable), .currentSetpoint(currentSetpoint),
        .speedSetpoint(speedSetpoint), .slowReverse(slowReverse), .threeWire(threeWire),
        .failedThyristorTrip(failedThyristorTrip), .stackOverloadTrip(stackOverloadTrip),
        .slowLimitReached(slowLimitReached));

    mss_far_side u_mss_far_side (
        .ref_clk(ref_clk), .startIn(startIn), .digitalIn(digitalIn),
        .slowKickTime(slowKickTime));

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Counts limit pulses away from the edge that launches them
    always @(negedge ref_clk) if (slowLimitReached) limitPulses++;

    // Prints the counts and the verdict, then stops
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // One comparison
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Watched conditions: relay bits 0..3, then setpoint at slow level
    function automatic logic sig(input int k);
        sig = (k < 4) ? relayOut[k] : (currentSetpoint === slowCurrentLevel);
    endfunction

    // Waits at most lim cycles for a condition; n is the cycles spent
    task automatic waitFor(input int k, input logic v, input int lim, output int n);
        n = 0;
        #1;
        while (sig(k) !== v) begin
            if (n == lim) begin
                miscompares++;
                $display("Error wait%0d expected %0h seen %0h", k, v, sig(k));
                give_verdict();
            end
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    // Lets cycles pass and settles past the edge
    task automatic idle(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    // Hand mode: a momentary start is held until the stop circuit opens
    task automatic threeWireRun();
        int n;
        u_mss_far_side.hand(1'b1);
        u_mss_far_side.start(1'b1);
        u_mss_far_side.start(1'b0);
        waitFor(0, 1'b1, 4, n);
        check("threeWire", 16'h0001, 16'(threeWire));
        idle(20);
        check("run held", 16'h0001, 16'(relayOut[0]));
        u_mss_far_side.hand(1'b0);
        waitFor(0, 1'b0, 4, n);
    endtask

    // Auto mode: runs only while the run contact stays closed
    task automatic twoWireRun();
        int n;
        u_mss_far_side.start(1'b1);
        waitFor(0, 1'b1, 4, n);
        check("threeWire", 16'h0000, 16'(threeWire));
        u_mss_far_side.slow(1'b1, 1'b0);
        idle(6);
        check("slow while running", 16'h0000, 16'(relayOut[2]));
        u_mss_far_side.slow(1'b0, 1'b0);
        u_mss_far_side.start(1'b0);
        waitFor(0, 1'b0, 4, n);
    endtask

    // Direct-online: no gates, no setpoint, thyristor and stack faults masked
    task automatic directOnline();
        int n;
        @(posedge ref_clk) directOnlineMode <= 1'b1;
        u_mss_far_side.hand(1'b1);
        u_mss_far_side.start(1'b1);
        u_mss_far_side.start(1'b0);
        waitFor(0, 1'b1, 4, n);
        @(posedge ref_clk) begin
            motorAtSpeed <= 1'b1;
            failedThyristorIn <= 1'b1;
            stackOverloadIn <= 1'b1;
        end
        waitFor(1, 1'b1, 4, n);
        idle(3);
        check("gateEnable", 16'h0000, 16'(gateEnable));
        check("currentSetpoint", 16'h0000, 16'(currentSetpoint));
        check("failedThyristorTrip", 16'h0000, 16'(failedThyristorTrip));
        check("stackOverloadTrip", 16'h0000, 16'(stackOverloadTrip));
        @(posedge ref_clk) begin
            motorAtSpeed <= 1'b0;
            failedThyristorIn <= 1'b0;
            stackOverloadIn <= 1'b0;
        end
        u_mss_far_side.hand(1'b0);
        waitFor(0, 1'b0, 4, n);
        u_mss_far_side.hand(1'b1);
        u_mss_far_side.start(1'b1);
        u_mss_far_side.start(1'b0);
        waitFor(0, 1'b1, 4, n);
        @(posedge ref_clk) faultTrip <= 1'b1;
        waitFor(0, 1'b0, 4, n);
        u_mss_far_side.hand(1'b0);
        @(posedge ref_clk) begin
            directOnlineMode <= 1'b0;
            faultTrip <= 1'b0;
        end
    endtask

    // Slow requests with speed Off, then from the keypad source
    task automatic slowRefused();
        @(posedge ref_clk) slowSpeedSel <= 4'h0;
        u_mss_far_side.slow(1'b1, 1'b0);
        idle(6);
        check("slow with speed off", 16'h0000, 16'(relayOut[2]));
        @(posedge ref_clk) begin
            slowSpeedSel <= 4'h5;
            sourceTerminal <= 1'b0;
        end
        idle(6);
        check("slow from keypad", 16'h0000, 16'(relayOut[2]));
        u_mss_far_side.slow(1'b0, 1'b0);
        @(posedge ref_clk) sourceTerminal <= 1'b1;
    endtask

    // Kick then slow level, ended by the limit; second pass starts timing afresh
    task automatic slowKickRun();
        int n;
        int t;
        @(posedge ref_clk) begin
            slowKickLevel <= 8'h60;
            slowTimeLimit <= 16'h0010;
        end
        for (int k = 0; k < 2; k++) begin
            u_mss_far_side.tuneKick(k);
            u_mss_far_side.slow(1'b1, 1'b0);
            waitFor(2, 1'b1, 6, n);
            check("kick level", 16'h0060, 16'(currentSetpoint));
            check("speedSetpoint", 16'h0005, 16'(speedSetpoint));
            check("slowReverse", 16'h0000, 16'(slowReverse));
            waitFor(4, 1'b1, 200, n);
            check("kick span", 16'h0001, 16'(n >= (9 + k) * 10 && n <= (11 + k) * 10));
            waitFor(2, 1'b0, 200, t);
            check("limit span", 16'h0001, 16'(n + t >= 150 && n + t <= 175));
            check("limit pulses", 16'(k + 1), 16'(limitPulses));
            idle(4);
            check("held after limit", 16'h0000, 16'(relayOut[2]));
            u_mss_far_side.slow(1'b0, 1'b0);
            idle(4);
            waitFor(2, 1'b0, 20, t);
            idle(4);
        end
    endtask

    // Reverse with kick and limit Off: slow level at once, runs past any limit
    task automatic slowReverseNoKick();
        int n;
        @(posedge ref_clk) begin
            slowKickLevel <= 8'h00;
            slowTimeLimit <= 16'h0000;
        end
        u_mss_far_side.slow(1'b0, 1'b1);
        waitFor(2, 1'b1, 6, n);
        check("no kick level", 16'h0020, 16'(currentSetpoint));
        check("slowReverse", 16'h0001, 16'(slowReverse));
        idle(250);
        check("no limit", 16'h0001, 16'(relayOut[2]));
        check("no limit pulse", 16'h0002, 16'(limitPulses));
        u_mss_far_side.slow(1'b0, 1'b0);
        waitFor(2, 1'b0, 6, n);
    endtask

    // Main sequence
    initial begin
        checked = 0;
        miscompares = 0;
        reset = 1'b1;
        sourceTerminal = 1'b1;
        directOnlineMode = 1'b0;
        motorAtSpeed = 1'b0;
        failedThyristorIn = 1'b0;
        stackOverloadIn = 1'b0;
        slowSpeedSel = 4'h5;
        slowCurrentLevel = 8'h20;
        slowKickLevel = 8'h60;
        slowTimeLimit = 16'h0000;
        rampCurrentLevel = 8'h40;
        diFunc = 12'h0D1;
        relayFunc = 8'h39;
        faultTrip = 1'b0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        idle(2);
        threeWireRun();
        twoWireRun();
        directOnline();
        slowRefused();
        slowKickRun();
        slowReverseNoKick();
        give_verdict();
    end
endmodule
`default_nettype wire
